// ==== inc/pio_pkg.sv ====
package pio_pkg;
    // Register offsets
    localparam logic [7:0] OFF_PORT_A_LATCH = 8'h00;
    localparam logic [7:0] OFF_PORT_B_LATCH = 8'h01;
    localparam logic [7:0] OFF_PORT_C_LATCH = 8'h02;
    localparam logic [7:0] OFF_PORT_D_LATCH = 8'h03;
    localparam logic [7:0] OFF_PORT_A_DIRECTION = 8'h04;
    localparam logic [7:0] OFF_PORT_B_DIRECTION = 8'h05;
    localparam logic [7:0] OFF_PORT_C_DIRECTION = 8'h06;
    localparam logic [7:0] OFF_PORT_D_DIRECTION = 8'h07;
    localparam logic [7:0] OFF_PORT_E_LATCH = 8'h08;
    localparam logic [7:0] OFF_PORT_F_LATCH = 8'h09;
    localparam logic [7:0] OFF_PORT_E_DIRECTION = 8'h0a;
    localparam logic [7:0] OFF_PORT_F_DIRECTION = 8'h0b;
    localparam logic [7:0] OFF_OPTICAL_INTERFACE_ENABLE = 8'h1c;
    // Reset values
    localparam logic [7:0] RST_DIRECTION = 8'h00;
    localparam logic [7:0] RST_OPTICAL_INTERFACE_ENABLE = 8'h48;
    // Implemented bit masks
    localparam logic [7:0] MASK_FULL = 8'hff;
    localparam logic [7:0] MASK_NARROW = 8'h1f;
    // Optical interface field positions
    localparam int VREF_MSB = 7;
    localparam int VREF_LSB = 5;
    localparam int HREF_MSB = 4;
    localparam int HREF_LSB = 2;
    localparam int VEN_BIT = 1;
    localparam int HEN_BIT = 0;
endpackage

// ==== hdl/pio_bank.sv ====
// Design decision made here: strobed register access.
`timescale 1ns/1ps
// Overview of operation
// - Every pin individually input or output
// - Port A eight bidirectional pins
// - Port A latch at offset 0x00
// - Port C latch bits 7:5 read zero
// - Port E latch bits 7:5 read zero
// - Directions A, B, D, F reset zero
// - Directions C, E five bits, reset zero
// - Port F latch 0x09, direction 0x0b
// - Optical enable fields, reset 0x48
// - Direction one drives pin, zero floats
// - Read: latch if output, pin if input
module pio_bank (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // Port pins
    input wire logic [7:0] port_a_in,
    output logic [7:0] port_a_out,
    output logic [7:0] port_a_oe,
    input wire logic [7:0] port_b_in,
    output logic [7:0] port_b_out,
    output logic [7:0] port_b_oe,
    input wire logic [4:0] port_c_in,
    output logic [4:0] port_c_out,
    output logic [4:0] port_c_oe,
    input wire logic [7:0] port_d_in,
    output logic [7:0] port_d_out,
    output logic [7:0] port_d_oe,
    input wire logic [4:0] port_e_in,
    output logic [4:0] port_e_out,
    output logic [4:0] port_e_oe,
    input wire logic [7:0] port_f_in,
    output logic [7:0] port_f_out,
    output logic [7:0] port_f_oe,
    // Optical interface controls
    output logic [2:0] vertical_reference_level,
    output logic [2:0] horizontal_reference_level,
    output logic vertical_optical_enable,
    output logic horizontal_optical_enable
);

    localparam int NPORT = 6;

    // Register state
    logic [7:0] latch [NPORT];
    logic [7:0] dir [NPORT];
    logic [7:0] sync1 [NPORT];
    logic [7:0] sync2 [NPORT];
    logic [7:0] optical_interface_enable;
    logic [7:0] pin_in [NPORT];
    logic [7:0] next_rdata;
    logic [NPORT-1:0] latch_we;
    logic [NPORT-1:0] dir_we;
    logic opt_we;

    // Port index of a latch offset, or NPORT when none
    function automatic int latch_index(input logic [7:0] a);
        case (a)
            pio_pkg::OFF_PORT_A_LATCH: latch_index = 0;
            pio_pkg::OFF_PORT_B_LATCH: latch_index = 1;
            pio_pkg::OFF_PORT_C_LATCH: latch_index = 2;
            pio_pkg::OFF_PORT_D_LATCH: latch_index = 3;
            pio_pkg::OFF_PORT_E_LATCH: latch_index = 4;
            pio_pkg::OFF_PORT_F_LATCH: latch_index = 5;
            default: latch_index = NPORT;
        endcase
    endfunction

    // Port index of a direction offset, or NPORT when none
    function automatic int dir_index(input logic [7:0] a);
        case (a)
            pio_pkg::OFF_PORT_A_DIRECTION: dir_index = 0;
            pio_pkg::OFF_PORT_B_DIRECTION: dir_index = 1;
            pio_pkg::OFF_PORT_C_DIRECTION: dir_index = 2;
            pio_pkg::OFF_PORT_D_DIRECTION: dir_index = 3;
            pio_pkg::OFF_PORT_E_DIRECTION: dir_index = 4;
            pio_pkg::OFF_PORT_F_DIRECTION: dir_index = 5;
            default: dir_index = NPORT;
        endcase
    endfunction

    // Implemented bits of each port
    function automatic logic [7:0] port_mask(input int p);
        if (p == 2 || p == 4) begin
            port_mask = pio_pkg::MASK_NARROW;
        end else begin
            port_mask = pio_pkg::MASK_FULL;
        end
    endfunction

    // Pin inputs gathered, narrow ports padded
    always_comb begin
        pin_in[0] = port_a_in;
        pin_in[1] = port_b_in;
        pin_in[2] = {3'b000, port_c_in};
        pin_in[3] = port_d_in;
        pin_in[4] = {3'b000, port_e_in};
        pin_in[5] = port_f_in;
    end

    // Write decode, one strobe per register
    always_comb begin
        latch_we = '0;
        dir_we = '0;
        opt_we = 1'b0;
        if (wr) begin
            for (int p = 0; p < NPORT; p++) begin
                latch_we[p] = (latch_index(addr) == p);
                dir_we[p] = (dir_index(addr) == p);
            end
            opt_we = (addr == pio_pkg::OFF_OPTICAL_INTERFACE_ENABLE);
        end
    end

    genvar g;
    generate
        for (g = 0; g < NPORT; g++) begin : gen_port
            // Two-stage synchroniser
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    sync1[g] <= 8'h00;
                    sync2[g] <= 8'h00;
                end else begin
                    sync1[g] <= pin_in[g];
                    sync2[g] <= sync1[g];
                end
            end

            // Data latch, untouched by reset
            always_ff @(posedge clk) begin
                if (latch_we[g]) begin
                    latch[g] <= wdata & port_mask(g);
                end
            end

            // Direction register
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    dir[g] <= pio_pkg::RST_DIRECTION;
                end else if (dir_we[g]) begin
                    dir[g] <= wdata & port_mask(g);
                end
            end
        end
    endgenerate

    // Optical interface enable register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            optical_interface_enable <= pio_pkg::RST_OPTICAL_INTERFACE_ENABLE;
        end else if (opt_we) begin
            optical_interface_enable <= wdata;
        end
    end

    // Read mux
    always_comb begin
        next_rdata = 8'h00;
        if (latch_index(addr) != NPORT) begin
            for (int p = 0; p < NPORT; p++) begin
                if (latch_index(addr) == p) begin
                    next_rdata = ((dir[p] & latch[p]) | (~dir[p] & sync2[p]))
                        & port_mask(p);
                end
            end
        end else if (dir_index(addr) != NPORT) begin
            for (int p = 0; p < NPORT; p++) begin
                if (dir_index(addr) == p) begin
                    next_rdata = dir[p];
                end
            end
        end else if (addr == pio_pkg::OFF_OPTICAL_INTERFACE_ENABLE) begin
            next_rdata = optical_interface_enable;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (rd) begin
            rdata <= next_rdata;
        end else begin
            rdata <= 8'h00;
        end
    end

    // Port A drive enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_a_oe <= pio_pkg::RST_DIRECTION;
        end else begin
            port_a_oe <= dir[0];
        end
    end

    // Port B drive enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_b_oe <= pio_pkg::RST_DIRECTION;
        end else begin
            port_b_oe <= dir[1];
        end
    end

    // Port C drive enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_c_oe <= pio_pkg::RST_DIRECTION[4:0];
        end else begin
            port_c_oe <= dir[2][4:0];
        end
    end

    // Port D drive enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_d_oe <= pio_pkg::RST_DIRECTION;
        end else begin
            port_d_oe <= dir[3];
        end
    end

    // Port E drive enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_e_oe <= pio_pkg::RST_DIRECTION[4:0];
        end else begin
            port_e_oe <= dir[4][4:0];
        end
    end

    // Port F drive enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_f_oe <= pio_pkg::RST_DIRECTION;
        end else begin
            port_f_oe <= dir[5];
        end
    end

    // Port A pin value, zero under reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_a_out <= 8'h00;
        end else begin
            port_a_out <= latch[0];
        end
    end

    // Port B pin value
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_b_out <= 8'h00;
        end else begin
            port_b_out <= latch[1];
        end
    end

    // Port C pin value
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_c_out <= 5'h00;
        end else begin
            port_c_out <= latch[2][4:0];
        end
    end

    // Port D pin value
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_d_out <= 8'h00;
        end else begin
            port_d_out <= latch[3];
        end
    end

    // Port E pin value
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_e_out <= 5'h00;
        end else begin
            port_e_out <= latch[4][4:0];
        end
    end

    // Port F pin value
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_f_out <= 8'h00;
        end else begin
            port_f_out <= latch[5];
        end
    end

    // Vertical reference level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vertical_reference_level <=
                pio_pkg::RST_OPTICAL_INTERFACE_ENABLE[pio_pkg::VREF_MSB:pio_pkg::VREF_LSB];
        end else begin
            vertical_reference_level <=
                optical_interface_enable[pio_pkg::VREF_MSB:pio_pkg::VREF_LSB];
        end
    end

    // Horizontal reference level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            horizontal_reference_level <=
                pio_pkg::RST_OPTICAL_INTERFACE_ENABLE[pio_pkg::HREF_MSB:pio_pkg::HREF_LSB];
        end else begin
            horizontal_reference_level <=
                optical_interface_enable[pio_pkg::HREF_MSB:pio_pkg::HREF_LSB];
        end
    end

    // Vertical optical enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vertical_optical_enable <= pio_pkg::RST_OPTICAL_INTERFACE_ENABLE[pio_pkg::VEN_BIT];
        end else begin
            vertical_optical_enable <= optical_interface_enable[pio_pkg::VEN_BIT];
        end
    end

    // Horizontal optical enable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            horizontal_optical_enable <= pio_pkg::RST_OPTICAL_INTERFACE_ENABLE[pio_pkg::HEN_BIT];
        end else begin
            horizontal_optical_enable <= optical_interface_enable[pio_pkg::HEN_BIT];
        end
    end

endmodule

// ==== tb/pio_bank_props.sv ====
`timescale 1ns/1ps
module pio_bank_props (
    // Clock, reset and register port
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    // Watched pins and controls
    input wire logic [7:0] port_a_in,
    input wire logic [7:0] port_a_out,
    input wire logic [7:0] port_a_oe,
    input wire logic [4:0] port_c_oe,
    input wire logic [2:0] vertical_reference_level,
    input wire logic [2:0] horizontal_reference_level,
    input wire logic vertical_optical_enable,
    input wire logic horizontal_optical_enable
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] opt;
    assign opt = {vertical_reference_level, horizontal_reference_level,
        vertical_optical_enable, horizontal_optical_enable};
    chk_dir_write: assert property (
        wr && addr == 8'h04 |-> ##2 port_a_oe == $past(wdata, 2))
        else $error("port A enable wrong");
    chk_narrow_dir: assert property (
        wr && addr == 8'h06 |-> ##2 port_c_oe == $past(wdata[4:0], 2))
        else $error("port C enable wrong");
    chk_latch_write: assert property (
        wr && addr == 8'h00 |-> ##2 port_a_out == $past(wdata, 2))
        else $error("port A output wrong");
    chk_opt_write: assert property (wr && addr == 8'h1c |-> ##2 opt == $past(wdata, 2))
        else $error("optical controls wrong");
    chk_narrow_read: assert property (
        rd && addr inside {8'h02, 8'h06, 8'h08, 8'h0a} |=> rdata[7:5] == 3'h0)
        else $error("unused bits not zero");
    chk_unmapped_read: assert property (
        rd && addr inside {[8'h0c:8'h1b], [8'h1d:8'hff]} |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_pin_read: assert property (
        rd && addr == 8'h00 && port_a_oe == 8'h00 && !$past(wr) && $stable(port_a_in)
        && port_a_in == $past(port_a_in, 2) |=> rdata == $past(port_a_in))
        else $error("input read wrong");
    chk_out_read: assert property (
        rd && addr == 8'h00 && port_a_oe == 8'hff && !$past(wr)
        |=> rdata == $past(port_a_out))
        else $error("output read wrong");
    chk_reset_vals: assert property (
        $rose(rst_n) |-> port_a_oe == 8'h00 && port_c_oe == 5'h00 && opt == 8'h48)
        else $error("reset values wrong");
endmodule
bind pio_bank pio_bank_props pio_bank_props_i (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .port_a_in(port_a_in),
    .port_a_out(port_a_out), .port_a_oe(port_a_oe), .port_c_oe(port_c_oe),
    .vertical_reference_level(vertical_reference_level),
    .horizontal_reference_level(horizontal_reference_level),
    .vertical_optical_enable(vertical_optical_enable),
    .horizontal_optical_enable(horizontal_optical_enable));

// ==== tb/pio_board.sv ====
`timescale 1ns/1ps
module pio_board #(parameter int W = 8) (
    // Board side and device side of each pin
    input wire logic [W-1:0] drv,
    input wire logic [W-1:0] out,
    input wire logic [W-1:0] oe,
    output logic [W-1:0] pin
);
    // Device drives where enabled, board elsewhere
    assign pin = (oe & out) | (~oe & drv);
endmodule

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] drv = 8'h00;
    logic [7:0] rdata, a_i, a_o, a_e, b_i, b_o, b_e, d_i, d_o, d_e, f_i, f_o, f_e;
    logic [4:0] c_i, c_o, c_e, e_i, e_o, e_e;
    logic [2:0] vref, href;
    logic ven, hen;
    int bad_count = 0;
    int tests_run = 0;
    localparam logic [7:0] DIRS [6] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h0a, 8'h0b};
    localparam logic [7:0] DATS [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08, 8'h09};
    localparam logic [7:0] MSK [6] = '{8'hff, 8'hff, 8'h1f, 8'hff, 8'h1f, 8'hff};
    localparam logic [7:0] DVS [3] = '{8'h0f, 8'hff, 8'h00};
    always #12.5 clk = ~clk;
    pio_bank pio_bank_i (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .port_a_in(a_i), .port_a_out(a_o), .port_a_oe(a_e),
        .port_b_in(b_i), .port_b_out(b_o), .port_b_oe(b_e), .port_c_in(c_i),
        .port_c_out(c_o), .port_c_oe(c_e), .port_d_in(d_i), .port_d_out(d_o),
        .port_d_oe(d_e), .port_e_in(e_i), .port_e_out(e_o), .port_e_oe(e_e),
        .port_f_in(f_i), .port_f_out(f_o), .port_f_oe(f_e),
        .vertical_reference_level(vref), .horizontal_reference_level(href),
        .vertical_optical_enable(ven), .horizontal_optical_enable(hen));
    pio_board #(8) brd_a (.drv(drv), .out(a_o), .oe(a_e), .pin(a_i));
    pio_board #(8) brd_b (.drv(drv), .out(b_o), .oe(b_e), .pin(b_i));
    pio_board #(5) brd_c (.drv(drv[4:0]), .out(c_o), .oe(c_e), .pin(c_i));
    pio_board #(8) brd_d (.drv(drv), .out(d_o), .oe(d_e), .pin(d_i));
    pio_board #(5) brd_e (.drv(drv[4:0]), .out(e_o), .oe(e_e), .pin(e_i));
    pio_board #(8) brd_f (.drv(drv), .out(f_o), .oe(f_e), .pin(f_i));
    task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check($sformatf("reg %h", a), rdata, exp);
    endtask
    task automatic t_reset_vals;
        for (int i = 0; i < 6; i++) rd_chk(DIRS[i], 8'h00);
        rd_chk(8'h1c, 8'h48);
    endtask
    task automatic t_regs;
        for (int i = 0; i < 6; i++) begin
            wr_reg(DIRS[i], 8'hff);
            rd_chk(DIRS[i], MSK[i]);
        end
        check("port c enable", {3'b000, c_e}, 8'h1f);
        wr_reg(8'h1c, 8'hb5);
        rd_chk(8'h1c, 8'hb5);
        check("optical fields", {vref, href, ven, hen}, 8'hb5);
        wr_reg(8'h1c, 8'h4a);
        rd_chk(8'h1c, 8'h4a);
        check("optical fields", {vref, href, ven, hen}, 8'h4a);
        wr_reg(8'h0c, 8'hff);
        rd_chk(8'h0c, 8'h00);
        rd_chk(8'h1d, 8'h00);
    endtask
    task automatic t_data;
        for (int i = 0; i < 6; i++) wr_reg(DIRS[i], 8'h00);
        for (int i = 0; i < 6; i++) wr_reg(DATS[i], 8'h3c);
        drv <= 8'ha5;
        for (int k = 0; k < 3; k++) begin
            logic [7:0] mix;
            mix = (DVS[k] & 8'h3c) | (~DVS[k] & 8'ha5);
            for (int i = 0; i < 6; i++) wr_reg(DIRS[i], DVS[k]);
            for (int i = 0; i < 6; i++) begin
                rd_chk(DATS[i], mix & MSK[i]);
            end
            check("port a enable", a_e, DVS[k]);
            check("port b enable", b_e, DVS[k]);
            check("port c enable", {3'h0, c_e}, DVS[k] & 8'h1f);
            check("port d enable", d_e, DVS[k]);
            check("port e enable", {3'h0, e_e}, DVS[k] & 8'h1f);
            check("port f enable", f_e, DVS[k]);
            check("port a output", a_o, 8'h3c);
            check("port b output", b_o, 8'h3c);
            check("port c output", {3'h0, c_o}, 8'h1c);
            check("port d output", d_o, 8'h3c);
            check("port e output", {3'h0, e_o}, 8'h1c);
            check("port f output", f_o, 8'h3c);
        end
    endtask
    task automatic t_retain;
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        t_reset_vals();
        wr_reg(8'h04, 8'hff);
        wr_reg(8'h0a, 8'h1f);
        rd_chk(8'h00, 8'h3c);
        rd_chk(8'h08, 8'h1c);
        check("port a output kept", a_o, 8'h3c);
    endtask
    task automatic stop_test;
        if (bad_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_reset_vals();
        t_regs();
        t_data();
        t_retain();
        stop_test();
    end
    initial begin
        #20000;
        bad_count++;
        stop_test();
    end
endmodule
